// >>> hdl/dsp_alu_mult_logic_ops.v
// Accumulator execution block for multiply step, no-op, invert and OR, with an APB slave.
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_defines.vh"

module dsp_alu_mult_logic_ops #(
  parameter WIDTH = 32,
  parameter ADDR_WIDTH = 8
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire [ADDR_WIDTH-1:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [WIDTH-1:0] pwdata_in,
  output reg [WIDTH-1:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out
);

  // ****************************************************************
  // Architectural state
  // ****************************************************************
  reg [WIDTH-1:0] acc_a_reg;
  reg [WIDTH-1:0] acc_b_reg;
  reg [WIDTH-1:0] acc_r_reg;
  reg [`FLAG_COUNT-1:0] flags_reg;
  reg [`OPCODE_WIDTH-1:0] opcode_reg;
  reg [WIDTH-1:0] exec_count_reg;
  reg [`STEP_COUNT_WIDTH-1:0] mult_steps_reg;

  reg [WIDTH-1:0] acc_a_next;
  reg [WIDTH-1:0] acc_b_next;
  reg [WIDTH-1:0] acc_r_next;
  reg [`FLAG_COUNT-1:0] flags_next;
  reg [`OPCODE_WIDTH-1:0] opcode_next;
  reg [WIDTH-1:0] exec_count_next;
  reg [`STEP_COUNT_WIDTH-1:0] mult_steps_next;

  reg [WIDTH-1:0] prdata_next;
  reg pready_next;
  reg pslverr_next;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [7:0] addr_byte = paddr_in[7:0];
  wire addr_aligned = (addr_byte & `ADDR_ALIGN_MASK) == `ADDR_ALIGNED;
  wire setup_phase = psel_in & ~penable_in;
  wire access_done = psel_in & penable_in & pready_out;
  wire access_ok = access_done & ~pslverr_out;
  wire write_ok = access_ok & pwrite_in;

  reg addr_mapped;

  always @* begin
    case (addr_byte)
      `ADDR_ACC_A: addr_mapped = addr_aligned;
      `ADDR_ACC_B: addr_mapped = addr_aligned;
      `ADDR_ACC_R: addr_mapped = addr_aligned;
      `ADDR_OPCODE: addr_mapped = addr_aligned;
      `ADDR_FLAGS: addr_mapped = addr_aligned;
      `ADDR_EXEC_COUNT: addr_mapped = addr_aligned;
      `ADDR_MULT_STEPS: addr_mapped = addr_aligned;
      default: addr_mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Instruction datapath
  // ****************************************************************
  wire [WIDTH-1:0] exec_a;
  wire [WIDTH-1:0] exec_b;
  wire [WIDTH-1:0] exec_r;
  wire [`FLAG_COUNT-1:0] exec_flags;
  wire exec_is_mult;
  wire [`OPCODE_WIDTH-1:0] exec_opcode = pwdata_in[`OPCODE_WIDTH-1:0];

  alu_step_unit #(
    .WIDTH(WIDTH)
  ) u_step (
    .opcode_in(exec_opcode),
    .acc_a_in(acc_a_reg),
    .acc_b_in(acc_b_reg),
    .acc_r_in(acc_r_reg),
    .flags_in(flags_reg),
    .acc_a_out(exec_a),
    .acc_b_out(exec_b),
    .acc_r_out(exec_r),
    .flags_out(exec_flags),
    .is_mult_out(exec_is_mult)
  );

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  // The two counters get no strobe, so a write to them is dropped without an error.
  wire wr_acc_a = write_ok & (addr_byte == `ADDR_ACC_A);
  wire wr_acc_b = write_ok & (addr_byte == `ADDR_ACC_B);
  wire wr_acc_r = write_ok & (addr_byte == `ADDR_ACC_R);
  wire wr_opcode = write_ok & (addr_byte == `ADDR_OPCODE);
  wire wr_flags = write_ok & (addr_byte == `ADDR_FLAGS);

  // ****************************************************************
  // Accumulator next values
  // ****************************************************************
  // Execution happens on the same edge as the opcode write, so there is no busy window
  // and a following accumulator access always sees the finished result.
  always @* begin
    acc_a_next = acc_a_reg;
    if (wr_acc_a) begin
      acc_a_next = pwdata_in; // Firmware clears this before a multiply.
    end else if (wr_opcode) begin
      acc_a_next = exec_a;
    end
  end

  always @* begin
    acc_b_next = acc_b_reg;
    if (wr_acc_b) begin
      acc_b_next = pwdata_in;
    end else if (wr_opcode) begin
      acc_b_next = exec_b;
    end
  end

  always @* begin
    acc_r_next = acc_r_reg;
    if (wr_acc_r) begin
      acc_r_next = pwdata_in;
    end else if (wr_opcode) begin
      acc_r_next = exec_r;
    end
  end

  // ****************************************************************
  // Status and counter next values
  // ****************************************************************
  always @* begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = pwdata_in[`FLAG_COUNT-1:0];
    end else if (wr_opcode) begin
      flags_next = exec_flags; // A no-op leaves all of these as they were.
    end
  end

  always @* begin
    opcode_next = opcode_reg;
    if (wr_opcode) begin
      opcode_next = exec_opcode;
    end
  end

  always @* begin
    exec_count_next = exec_count_reg;
    if (wr_opcode) begin
      exec_count_next = exec_count_reg + `COUNT_ONE;
    end
  end

  // The step counter wraps at 64; firmware tracks its own step count.
  always @* begin
    mult_steps_next = mult_steps_reg;
    if (wr_opcode) begin
      if (exec_is_mult) begin
        mult_steps_next = mult_steps_reg + `STEP_ONE;
      end else begin
        mult_steps_next = `RST_STEPS;
      end
    end
  end

  // ****************************************************************
  // Read data and bus answer
  // ****************************************************************
  // The answer is prepared in the setup cycle, so every access phase completes at once.
  always @* begin
    prdata_next = `RST_WORD;
    pready_next = setup_phase;
    pslverr_next = setup_phase & ~addr_mapped;
    if (setup_phase && !pwrite_in && addr_mapped) begin
      case (addr_byte)
        `ADDR_ACC_A: prdata_next = acc_a_reg;
        `ADDR_ACC_B: prdata_next = acc_b_reg;
        `ADDR_ACC_R: prdata_next = acc_r_reg;
        `ADDR_OPCODE: prdata_next = {{(WIDTH-`OPCODE_WIDTH){1'b0}}, opcode_reg};
        `ADDR_FLAGS: prdata_next = {{(WIDTH-`FLAG_COUNT){1'b0}}, flags_reg};
        `ADDR_EXEC_COUNT: prdata_next = exec_count_reg;
        `ADDR_MULT_STEPS: prdata_next = {{(WIDTH-`STEP_COUNT_WIDTH){1'b0}}, mult_steps_reg};
        default: prdata_next = `RST_WORD;
      endcase
    end
  end

  // ****************************************************************
  // Accumulator flip-flops
  // ****************************************************************
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      acc_a_reg <= `RST_WORD;
    end else begin
      acc_a_reg <= acc_a_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      acc_b_reg <= `RST_WORD;
    end else begin
      acc_b_reg <= acc_b_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      acc_r_reg <= `RST_WORD;
    end else begin
      acc_r_reg <= acc_r_next;
    end
  end

  // ****************************************************************
  // Status and counter flip-flops
  // ****************************************************************
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      flags_reg <= `RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      opcode_reg <= `RST_OPCODE;
    end else begin
      opcode_reg <= opcode_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      exec_count_reg <= `RST_COUNT;
    end else begin
      exec_count_reg <= exec_count_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      mult_steps_reg <= `RST_STEPS;
    end else begin
      mult_steps_reg <= mult_steps_next;
    end
  end

  // ****************************************************************
  // Bus answer flip-flops
  // ****************************************************************
  // The answer is registered so every bus output leaves a flip-flop; the price is
  // that the decode must finish within the setup cycle.
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      prdata_out <= `RST_WORD;
    end else begin
      prdata_out <= prdata_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= pready_next;
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= pslverr_next;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/alu_ops_defines.vh
// Constants shared by the accumulator execution block and its step unit.
`ifndef ALU_OPS_DEFINES_VH
`define ALU_OPS_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_ACC_A 8'h00
`define ADDR_ACC_B 8'h04
`define ADDR_ACC_R 8'h08
`define ADDR_OPCODE 8'h0c
`define ADDR_FLAGS 8'h10
`define ADDR_EXEC_COUNT 8'h14
`define ADDR_MULT_STEPS 8'h18

// ****************************************************************
// Opcode encoding: one-byte opcodes, 4-bit class and 2-bit operand fields
// ****************************************************************
`define OPCODE_WIDTH 8
`define OPC_NOP 8'h00
`define OPC_MULT 8'h01
`define OPC_CLASS_MISC 4'h0
`define OPC_CLASS_NOT 4'h1
`define OPC_CLASS_OR 4'h2
`define OPC_PAD_ZERO 2'h0
`define SEL_ACC_A 2'h0
`define SEL_ACC_B 2'h1
`define SEL_ACC_R 2'h2
`define SEL_NONE 2'h3

// ****************************************************************
// Flag register layout
// ****************************************************************
`define FLAG_COUNT 5
`define FLAG_C 0
`define FLAG_O 1
`define FLAG_S 2
`define FLAG_Z 3
`define FLAG_ILLEGAL 4

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define RST_WORD 32'h00000000
`define RST_FLAGS 5'h00
`define RST_OPCODE 8'h00
`define RST_COUNT 32'h00000000
`define RST_STEPS 6'h00
`define STEP_COUNT_WIDTH 6
`define STEP_ONE 6'h01
`define COUNT_ONE 32'h00000001
`define ADDR_ALIGN_MASK 8'h03
`define ADDR_ALIGNED 8'h00

`endif

// >>> hdl/alu_step_unit.v
// Combinational datapath that executes one accumulator instruction.
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_defines.vh"

module alu_step_unit #(
  parameter WIDTH = 32
) (
  input wire [`OPCODE_WIDTH-1:0] opcode_in,
  input wire [WIDTH-1:0] acc_a_in,
  input wire [WIDTH-1:0] acc_b_in,
  input wire [WIDTH-1:0] acc_r_in,
  input wire [`FLAG_COUNT-1:0] flags_in,
  output reg [WIDTH-1:0] acc_a_out,
  output reg [WIDTH-1:0] acc_b_out,
  output reg [WIDTH-1:0] acc_r_out,
  output reg [`FLAG_COUNT-1:0] flags_out,
  output reg is_mult_out
);

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  function [WIDTH-1:0] pick;
    input [1:0] sel;
    input [WIDTH-1:0] a;
    input [WIDTH-1:0] b;
    input [WIDTH-1:0] r;
    begin
      case (sel)
        `SEL_ACC_A: pick = a;
        `SEL_ACC_B: pick = b;
        default: pick = r;
      endcase
    end
  endfunction

  wire [3:0] op_class = opcode_in[7:4];
  wire [1:0] sel_first = opcode_in[3:2];
  wire [1:0] sel_second = opcode_in[1:0];
  wire [WIDTH-1:0] addend = acc_b_in[0] ? acc_r_in : {WIDTH{1'b0}};
  wire [WIDTH:0] step_sum = {1'b0, acc_a_in} + {1'b0, addend};
  wire [WIDTH-1:0] mult_a = {1'b0, step_sum[WIDTH-1:1]};
  wire [WIDTH-1:0] mult_b = {step_sum[0], acc_b_in[WIDTH-1:1]};

  reg [WIDTH-1:0] result;
  reg [1:0] dest;
  reg logic_write;

  // ****************************************************************
  // Instruction execution
  // ****************************************************************
  always @* begin
    acc_a_out = acc_a_in;
    acc_b_out = acc_b_in;
    acc_r_out = acc_r_in;
    flags_out = flags_in;
    is_mult_out = 1'b0;
    result = {WIDTH{1'b0}};
    dest = `SEL_NONE;
    logic_write = 1'b0;
    case (op_class)
      `OPC_CLASS_MISC: begin
        if (opcode_in == `OPC_MULT) begin
          // Bit 31 of the upper half is forced low, so the carry out of the sum is lost.
          acc_a_out = mult_a;
          acc_b_out = mult_b;
          is_mult_out = 1'b1;
          flags_out[`FLAG_S] = mult_a[WIDTH-1];
          flags_out[`FLAG_Z] = ~|{mult_a, mult_b};
        end else if (opcode_in != `OPC_NOP) begin
          flags_out[`FLAG_ILLEGAL] = 1'b1;
        end
      end
      `OPC_CLASS_NOT: begin
        if (sel_first == `OPC_PAD_ZERO && sel_second != `SEL_NONE) begin
          result = ~pick(sel_second, acc_a_in, acc_b_in, acc_r_in);
          dest = sel_second;
          logic_write = 1'b1;
        end else begin
          flags_out[`FLAG_ILLEGAL] = 1'b1;
        end
      end
      `OPC_CLASS_OR: begin
        // A repeated or missing operand is refused rather than executed.
        if (sel_first != sel_second && sel_first != `SEL_NONE && sel_second != `SEL_NONE) begin
          result = pick(sel_first, acc_a_in, acc_b_in, acc_r_in) |
            pick(sel_second, acc_a_in, acc_b_in, acc_r_in);
          dest = sel_first;
          logic_write = 1'b1;
        end else begin
          flags_out[`FLAG_ILLEGAL] = 1'b1;
        end
      end
      default: begin
        flags_out[`FLAG_ILLEGAL] = 1'b1;
      end
    endcase
    if (logic_write) begin
      case (dest)
        `SEL_ACC_A: acc_a_out = result;
        `SEL_ACC_B: acc_b_out = result;
        default: acc_r_out = result;
      endcase
      flags_out[`FLAG_C] = 1'b0;
      flags_out[`FLAG_O] = 1'b0;
      flags_out[`FLAG_S] = result[WIDTH-1];
      flags_out[`FLAG_Z] = ~|result;
    end
  end

endmodule

`default_nettype wire

// >>> tb/fw_mult_seq.sv
// Firmware model that issues the multiply-step instruction stream.
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_defines.vh"

module fw_mult_seq #(
  parameter int STEPS = 32
) (
  input wire logic [5:0] idx_in,
  output logic [7:0] opcode_out,
  output logic done_out
);
  // One step per multiplier bit, so a short multiplier costs fewer steps.
  assign opcode_out = `OPC_MULT;
  assign done_out = (idx_in >= STEPS);
endmodule
`default_nettype wire

// >>> tb/dsp_alu_monitor.sv
// Bus-side checker for the accumulator execution block.
`timescale 1ns/100ps
`default_nettype none

module dsp_alu_monitor #(
  parameter WIDTH = 32,
  parameter ADDR_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_WIDTH-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [WIDTH-1:0] pwdata_in,
  input wire logic [WIDTH-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out
);
  wire logic setup_c = psel_in && !penable_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ready_after_setup_a: assert property (setup_c |=> pready_out)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  ready_cause_a: assert property (pready_out |-> $past(setup_c) && psel_in && penable_in)
    else $error("ready without a request");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  misalign_err_a: assert property (setup_c && paddr_in[1:0] != 2'h0 |=> pslverr_out)
    else $error("misaligned access accepted");
  unmapped_err_a: assert property (setup_c && paddr_in > 8'h18 |=> pslverr_out)
    else $error("unmapped access accepted");
  mapped_ok_a: assert property (setup_c && paddr_in[1:0] == 2'h0 && paddr_in <= 8'h18
    |=> !pslverr_out) else $error("mapped access refused");
  idle_data_zero_a: assert property (!pready_out || pslverr_out |-> prdata_out == 32'h0)
    else $error("read data outside a good access");
  opcode_byte_a: assert property (setup_c && !pwrite_in && paddr_in == 8'h0c
    |=> prdata_out[31:8] == 24'h0) else $error("opcode wider than one byte");
  cover property (setup_c && pwrite_in ##1 pready_out);
  cover property (setup_c && !pwrite_in ##1 pready_out);
  cover property (pslverr_out);
endmodule
`default_nettype wire

// >>> tb/test_dsp_alu_mult_logic_ops.sv
// Self-checking bench for the accumulator execution block.
`timescale 1ns/100ps
`default_nettype none
`include "alu_ops_defines.vh"

module test_dsp_alu_mult_logic_ops;
  logic clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, err, fw_done;
  logic [7:0] paddr_in = 8'h00, fw_op;
  logic [5:0] fw_idx = 6'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdata, e;
  logic [31:0] v [3];
  logic [63:0] p;
  logic pready_out, pslverr_out;
  int fails = 0, check_count = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  dsp_alu_mult_logic_ops i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));
  fw_mult_seq i_fw (.idx_in(fw_idx), .opcode_out(fw_op), .done_out(fw_done));
  logic fw8_done;
  logic [7:0] fw8_op;
  logic [5:0] fw8_idx = 6'h00;
  fw_mult_seq #(.STEPS(8)) i_fw8 (.idx_in(fw8_idx), .opcode_out(fw8_op), .done_out(fw8_done));
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    check_count++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Request is held until ready is sampled high; no wait count is assumed.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= ad; pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rdata = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task rd(input string nm, input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(nm, x, rdata);
  endtask
  task ld(input logic [31:0] a, input logic [31:0] b, input logic [31:0] r);
    apb(1'b1, `ADDR_ACC_A, a);
    apb(1'b1, `ADDR_ACC_B, b);
    apb(1'b1, `ADDR_ACC_R, r);
  endtask
  function automatic logic [31:0] fl(input logic [31:0] x);
    return {28'h0, x == 32'h0, x[31], 2'b00};
  endfunction
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    apb(1'b1, `ADDR_FLAGS, 32'h3);
    ld(32'h80000001, 32'h3, 32'h0);
    apb(1'b1, `ADDR_OPCODE, {24'h0, `OPC_MULT});
    rd("step a", `ADDR_ACC_A, 32'h40000000);
    rd("step b", `ADDR_ACC_B, 32'h80000001);
    rd("step flags", `ADDR_FLAGS, 32'h3);
    ld(32'hffffffff, 32'h1, 32'h1);
    apb(1'b1, `ADDR_OPCODE, {24'h0, `OPC_MULT});
    rd("wrap a", `ADDR_ACC_A, 32'h0);
    rd("wrap b", `ADDR_ACC_B, 32'h0);
    rd("wrap flags", `ADDR_FLAGS, 32'hb);
    // Upper half is cleared first, since each step adds into it.
    ld(32'h0, 32'hdeadbeef, 32'h12345679);
    // The no-op breaks the run of steps, so the step counter starts from zero.
    apb(1'b1, `ADDR_OPCODE, {24'h0, `OPC_NOP});
    while (fw_done !== 1'b1) begin
      apb(1'b1, `ADDR_OPCODE, {24'h0, fw_op});
      fw_idx = fw_idx + 6'h1;
      #1;
    end
    p = 64'hdeadbeef * 64'h12345679;
    rd("prod hi", `ADDR_ACC_A, p[63:32]);
    rd("prod lo", `ADDR_ACC_B, p[31:0]);
    rd("multiplicand", `ADDR_ACC_R, 32'h12345679);
    rd("prod flags", `ADDR_FLAGS, 32'h3);
    rd("prod steps", `ADDR_MULT_STEPS, 32'h20);
    apb(1'b1, `ADDR_OPCODE, {24'h0, `OPC_NOP});
    rd("nop a", `ADDR_ACC_A, p[63:32]);
    rd("nop flags", `ADDR_FLAGS, 32'h3);
    rd("nop steps", `ADDR_MULT_STEPS, 32'h0);
    // An 8-bit multiplier needs eight steps; the product fills the top 40 bits.
    ld(32'h0, 32'h000000a5, 32'h00001234);
    while (fw8_done !== 1'b1) begin
      apb(1'b1, `ADDR_OPCODE, {24'h0, fw8_op});
      fw8_idx = fw8_idx + 6'h1;
      #1;
    end
    p = (64'h000000a5 * 64'h00001234) << 24;
    rd("short hi", `ADDR_ACC_A, p[63:32]);
    rd("short lo", `ADDR_ACC_B, p[31:0]);
    v[0] = 32'h0; v[1] = 32'h0000ffff; v[2] = 32'hffffffff;
    for (int s = 0; s < 3; s++) begin
      ld(v[0], v[1], v[2]);
      apb(1'b1, `ADDR_OPCODE, {24'h0, 4'h1, 2'h0, s[1:0]});
      rd("not", 8'(s * 4), ~v[s]);
      rd("not flags", `ADDR_FLAGS, fl(~v[s]));
    end
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (i != j) begin
          ld(v[0], v[1], v[2]);
          apb(1'b1, `ADDR_OPCODE, {24'h0, 4'h2, i[1:0], j[1:0]});
          e = v[i] | v[j];
          rd("or", 8'(i * 4), e);
          rd("or flags", `ADDR_FLAGS, fl(e));
        end
      end
    end
    // An OR naming one accumulator twice is refused: it sets the illegal flag and leaves the accumulators as they were.
    apb(1'b1, `ADDR_OPCODE, 32'h0000002a);
    rd("bad flags", `ADDR_FLAGS, 32'h14);
    rd("bad r", `ADDR_ACC_R, 32'hffffffff);
    rd("bad opcode", `ADDR_OPCODE, 32'h2a);
    apb(1'b1, `ADDR_EXEC_COUNT, 32'h0);
    rd("exec count", `ADDR_EXEC_COUNT, 32'h36);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdata);
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, err});
    give_verdict;
  end
endmodule

bind dsp_alu_mult_logic_ops dsp_alu_monitor #(.WIDTH(WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) i_mon (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire
